/* File: src/lmmx_exec.sv */
// Execute unit for load word, system register write, moves, address adds and multiplies.
//
// Behaviour
// - Load word address is base plus displacement
// - Decode load; displacement high bits from halfword
// - Mask low address bits unless misaligned allowed
// - Interrupt abandons load; return to load address
// - System register write copies source word
// - Source from first field, number from other
// - Number five updates status word bits
// - No interrupt sampling while status word written
// - Setting disable flag blocks interrupts immediately
// - Copy register, short immediate, or long immediate
// - Long immediate low then high halfword
// - Address add: base plus signed immediate
// - High add: base plus immediate shifted up
// - Word product: high to third, low second
// - Nine bit immediate from two fields, signed
// - Same destinations keep upper product half
// - Halfword product of low register halves
// - Short immediate halfword product, sign extended
// - Halfword immediate product into destination
`timescale 1ns/1ps
module lmmx_exec
    import lmmx_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Instruction issue from the decoder.
    input wire logic issue_i,
    input wire logic [47:0] insn_i,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] op_a_i,
    input wire logic [31:0] op_b_i,
    input wire logic [31:0] op_c_i,
    input wire logic misalign_en_i,
    input wire logic irq_i,
    output logic busy_o,
    output logic done_o,
    // Register file operand selects.
    output logic [4:0] rs_a_o,
    output logic [4:0] rs_b_o,
    output logic [4:0] rs_c_o,
    // Register file write ports.
    output lmmx_wr_t wr_a_o,
    output lmmx_wr_t wr_b_o,
    // Data memory read port.
    output logic mem_req_o,
    output logic [31:0] mem_addr_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    // Interrupt and system register side.
    output logic irq_take_o,
    output logic [31:0] irq_ret_pc_o,
    output logic sr_we_o,
    output logic [4:0] sr_num_o,
    output logic [31:0] sr_data_o,
    output logic [31:0] psw_o
);

    lmmx_regs_t r_r;
    lmmx_regs_t r_nxt;

    logic [4:0] f_reg1;
    logic [4:0] f_reg2;
    logic [5:0] f_op;
    logic [10:0] f_sub;
    logic is_system_register_write;
    logic is_mul;
    logic is_muli;
    logic irq_block;
    logic [63:0] prod64;
    logic [31:0] addr_raw;
    logic [31:0] mul_b;

    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction

    function automatic logic [31:0] sext5(input logic [4:0] v);
        sext5 = {{27{v[4]}}, v};
    endfunction

    function automatic logic [31:0] hmul(input logic [15:0] a, input logic [15:0] b);
        logic signed [31:0] p;
        p = $signed(a) * $signed(b);
        hmul = p;
    endfunction

    assign f_reg1 = insn_i[LMMX_REG1_LSB +: 5];
    assign f_reg2 = insn_i[LMMX_REG2_LSB +: 5];
    assign f_op = insn_i[LMMX_OP_LSB +: 6];
    assign f_sub = insn_i[26:16];
    assign is_system_register_write = (f_op == LMMX_OP_EXT) && (f_sub == LMMX_SUB_SYSTEM_REGISTER_WRITE);
    assign is_mul = (f_op == LMMX_OP_EXT) && (f_sub == LMMX_SUB_MUL);
    // Bits 21 to 18 carry the high immediate field, so the sub-opcode stops at bit 22.
    assign is_muli = (f_op == LMMX_OP_EXT) && (insn_i[26:22] == LMMX_SUB_MULI_HI)
        && (insn_i[17:16] == 2'h0);

    assign rs_a_o = f_reg1;
    assign rs_b_o = f_reg2;
    assign rs_c_o = insn_i[31:27];

    // Halfword displacement keeps bit 0 as the width bit, so only the upper 15 bits count.
    assign addr_raw = op_a_i + sext16({insn_i[31:17], 1'b0});

    // Operands are treated as signed; the immediate is nine bits from two fields.
    assign mul_b = is_muli ? {{23{insn_i[21]}}, insn_i[21:18], insn_i[4:0]} : op_a_i;
    // Both operands are widened to 64 bits first so the product never loses its upper half.
    assign prod64 = $signed({{32{op_b_i[31]}}, op_b_i}) * $signed({{32{mul_b[31]}}, mul_b});

    // A status word write that sets the disable flag blocks interrupts from its start.
    assign irq_block = issue_i && is_system_register_write;

    always_comb begin
        r_nxt = r_r;
        r_nxt.done = 1'b0;
        r_nxt.irq_taken = 1'b0;
        r_nxt.sr_we = 1'b0;
        r_nxt.wa.en = 1'b0;
        r_nxt.wb.en = 1'b0;
        case (r_r.st)
            LMMX_IDLE: begin
                if (issue_i) begin
                    r_nxt.done = 1'b1;
                    r_nxt.wa.idx = f_reg2;
                    r_nxt.wa.en = 1'b1;
                    case (f_op)
                        LMMX_OP_COPY: r_nxt.wa.data = op_a_i;
                        LMMX_OP_COPYI: begin
                            r_nxt.wa.data = sext5(insn_i[4:0]);
                        end
                        LMMX_OP_ADDRESS_ADD_IMMEDIATE: begin
                            // The address add never targets r0, so that field marks the long copy.
                            if (f_reg2 == 5'h00) begin
                                r_nxt.wa.idx = f_reg1;
                                r_nxt.wa.data = {insn_i[47:32], insn_i[31:16]};
                            end else begin
                                r_nxt.wa.data = op_a_i + sext16(insn_i[31:16]);
                            end
                        end
                        LMMX_OP_HIGH_HALFWORD_ADD: r_nxt.wa.data = op_a_i + {insn_i[31:16], 16'h0000};
                        LMMX_OP_HALFWORD_PRODUCT: r_nxt.wa.data = hmul(op_b_i[15:0], op_a_i[15:0]);
                        LMMX_OP_MULHI5: begin
                            r_nxt.wa.data = hmul(op_b_i[15:0], {{11{insn_i[4]}}, insn_i[4:0]});
                        end
                        LMMX_OP_HALFWORD_IMMEDIATE_PRODUCT: r_nxt.wa.data = hmul(op_a_i[15:0], insn_i[31:16]);
                        LMMX_OP_LOAD: begin
                            r_nxt.wa.en = 1'b0;
                            r_nxt.done = 1'b0;
                            r_nxt.busy = 1'b1;
                            r_nxt.st = LMMX_LOAD;
                            r_nxt.mem_req = 1'b1;
                            r_nxt.load_dst = f_reg2;
                            r_nxt.ret_pc = pc_i;
                            r_nxt.mem_addr = misalign_en_i ? addr_raw
                                : {addr_raw[31:2], addr_raw[1:0] & ~LMMX_WORD_MASK};
                        end
                        LMMX_OP_EXT: begin
                            if (is_system_register_write) begin
                                r_nxt.wa.en = 1'b0;
                                r_nxt.sr_we = 1'b1;
                                r_nxt.sr_num = f_reg2;
                                r_nxt.sr_data = op_a_i;
                                if (f_reg2 == LMMX_PSW_NUM) begin
                                    r_nxt.processor_status_word = op_a_i;
                                end
                            end else if (is_mul || is_muli) begin
                                // Both halves are written in the same cycle; the high write wins on a shared index.
                                r_nxt.wb.en = 1'b1;
                                r_nxt.wb.idx = f_reg2;
                                r_nxt.wb.data = prod64[31:0];
                                r_nxt.wa.idx = insn_i[31:27];
                                r_nxt.wa.data = prod64[63:32];
                                r_nxt.wa.en = (insn_i[31:27] != 5'h00) || (f_reg2 == 5'h00);
                            end else begin
                                r_nxt.wa.en = 1'b0;
                            end
                        end
                        default: r_nxt.wa.en = 1'b0;
                    endcase
                    if (irq_i && !irq_block && !r_r.processor_status_word[LMMX_ID_BIT] && f_op == LMMX_OP_LOAD) begin
                        r_nxt = r_r;
                        r_nxt.done = 1'b0;
                        r_nxt.wa.en = 1'b0;
                        r_nxt.wb.en = 1'b0;
                        r_nxt.sr_we = 1'b0;
                        r_nxt.irq_taken = 1'b1;
                        r_nxt.ret_pc = pc_i;
                    end
                end
            end
            LMMX_LOAD: begin
                if (irq_i && !r_r.processor_status_word[LMMX_ID_BIT]) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.busy = 1'b0;
                    r_nxt.irq_taken = 1'b1;
                    r_nxt.st = LMMX_IDLE;
                end else if (mem_ack_i) begin
                    r_nxt.mem_req = 1'b0;
                    r_nxt.wa.en = 1'b1;
                    r_nxt.wa.idx = r_r.load_dst;
                    r_nxt.wa.data = mem_rdata_i;
                    r_nxt.st = LMMX_DONE;
                end
            end
            LMMX_DONE: begin
                r_nxt.busy = 1'b0;
                r_nxt.done = 1'b1;
                r_nxt.st = LMMX_IDLE;
            end
            default: r_nxt.st = LMMX_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_r <= '0;
            r_r.processor_status_word <= LMMX_PSW_RST;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign busy_o = r_r.busy;
    assign done_o = r_r.done;
    assign wr_a_o = r_r.wa;
    assign wr_b_o = r_r.wb;
    assign mem_req_o = r_r.mem_req;
    assign mem_addr_o = r_r.mem_addr;
    assign irq_take_o = r_r.irq_taken;
    assign irq_ret_pc_o = r_r.ret_pc;
    assign sr_we_o = r_r.sr_we;
    assign sr_num_o = r_r.sr_num;
    assign sr_data_o = r_r.sr_data;
    assign psw_o = r_r.processor_status_word;

endmodule

/* File: src/lmmx_pkg.sv */
// Package with opcode fields, operation codes and constants for the execute block.
package lmmx_pkg;

    localparam int LMMX_W = 32;
    localparam logic [4:0] LMMX_PSW_NUM = 5'h05;
    localparam int LMMX_ID_BIT = 5;
    localparam logic [31:0] LMMX_PSW_RST = 32'h00000020;
    localparam int LMMX_REG1_LSB = 0;
    localparam int LMMX_REG2_LSB = 11;
    localparam int LMMX_OP_LSB = 5;
    localparam logic [5:0] LMMX_OP_COPY = 6'h00;
    localparam logic [5:0] LMMX_OP_HALFWORD_PRODUCT = 6'h07;
    localparam logic [5:0] LMMX_OP_COPYI = 6'h10;
    localparam logic [5:0] LMMX_OP_MULHI5 = 6'h17;
    localparam logic [5:0] LMMX_OP_ADDRESS_ADD_IMMEDIATE = 6'h31;
    localparam logic [5:0] LMMX_OP_HIGH_HALFWORD_ADD = 6'h32;
    localparam logic [5:0] LMMX_OP_HALFWORD_IMMEDIATE_PRODUCT = 6'h37;
    localparam logic [5:0] LMMX_OP_LOAD = 6'h39;
    localparam logic [5:0] LMMX_OP_EXT = 6'h3F;
    localparam logic [10:0] LMMX_SUB_SYSTEM_REGISTER_WRITE = 11'h020;
    localparam logic [10:0] LMMX_SUB_MUL = 11'h220;
    localparam logic [4:0] LMMX_SUB_MULI_HI = 5'h09;
    localparam logic [1:0] LMMX_WORD_MASK = 2'h3;

    typedef enum logic [1:0] {
        LMMX_IDLE = 2'b00,
        LMMX_LOAD = 2'b01,
        LMMX_DONE = 2'b10
    } lmmx_state_t;

    // One register file write port.
    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [31:0] data;
    } lmmx_wr_t;

    typedef struct packed {
        lmmx_state_t st;
        logic busy;
        logic done;
        logic irq_taken;
        logic [31:0] ret_pc;
        logic [31:0] processor_status_word;
        logic [31:0] sr_data;
        logic [4:0] sr_num;
        logic sr_we;
        logic mem_req;
        logic [31:0] mem_addr;
        logic [4:0] load_dst;
        lmmx_wr_t wa;
        lmmx_wr_t wb;
    } lmmx_regs_t;

endpackage

/* File: verif/lmmx_exec_sva.sv */
// Concurrent checks on the execute unit ports.
`timescale 1ns/1ps
module lmmx_exec_sva
    import lmmx_pkg::*;
(
    input wire logic clk_i, rstn_i, issue_i, misalign_en_i, irq_i,
    input wire logic [47:0] insn_i,
    input wire logic [31:0] op_a_i, op_b_i, mem_rdata_i, mem_addr_o, sr_data_o, psw_o,
    input wire logic busy_o, done_o, mem_req_o, mem_ack_i, irq_take_o, sr_we_o,
    input wire logic [4:0] sr_num_o,
    input wire lmmx_wr_t wr_a_o, wr_b_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic signed [63:0] prod;
    logic [31:0] ea;
    assign prod = $signed(op_b_i) * $signed(op_a_i);
    assign ea = op_a_i + {{16{insn_i[31]}}, insn_i[31:17], 1'b0};
    sequence s_take(op);
        issue_i && !busy_o && insn_i[10:5] == op;
    endsequence
    sequence s_ext(sub);
        s_take(LMMX_OP_EXT) ##0 insn_i[26:16] == sub;
    endsequence
    chk_load_start: assert property (s_take(LMMX_OP_LOAD) ##0 !irq_i |=> mem_req_o && busy_o)
        else $error("load did not start a read");
    chk_load_addr: assert property (s_take(LMMX_OP_LOAD) ##0 !irq_i |=> mem_addr_o ==
        ($past(misalign_en_i) ? $past(ea) : {$past(ea[31:2]), 2'b00})) else $error("bad address");
    chk_load_data: assert property (mem_req_o && mem_ack_i && !(irq_i && !psw_o[LMMX_ID_BIT])
        |=> wr_a_o.en && wr_a_o.data == $past(mem_rdata_i) ##1 done_o) else $error("bad load");
    chk_sr_write: assert property (s_ext(LMMX_SUB_SYSTEM_REGISTER_WRITE) |=> sr_we_o &&
        sr_num_o == $past(insn_i[15:11]) && sr_data_o == $past(op_a_i)) else $error("bad sr");
    chk_status_word: assert property (s_ext(LMMX_SUB_SYSTEM_REGISTER_WRITE) ##0 insn_i[15:11] == LMMX_PSW_NUM
        |=> psw_o[LMMX_ID_BIT] == $past(op_a_i[LMMX_ID_BIT])) else $error("bad status word");
    chk_sr_no_irq: assert property (s_ext(LMMX_SUB_SYSTEM_REGISTER_WRITE) ##0 irq_i |=> !irq_take_o)
        else $error("interrupt taken during status write");
    chk_irq_block: assert property (psw_o[LMMX_ID_BIT] && $past(psw_o[LMMX_ID_BIT]) |-> !irq_take_o)
        else $error("interrupt taken while disabled");
    chk_irq_abort: assert property (irq_take_o |-> !wr_a_o.en && !mem_req_o ##1 !wr_a_o.en)
        else $error("abandoned load still wrote");
    chk_mul_pair: assert property (s_ext(LMMX_SUB_MUL) ##0 insn_i[31:27] != insn_i[15:11] &&
        insn_i[31:27] != 5'h00 |=> wr_b_o.en && wr_b_o.data == $past(prod[31:0]) &&
        wr_a_o.data == $past(prod[63:32])) else $error("bad word product");
endmodule

/* File: verif/lmmx_exec_tb.sv */
// Self-checking bench for the execute unit.
`timescale 1ns/1ps
module lmmx_exec_tb;
    import lmmx_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue_i = 1'b0;
    logic misalign_en_i = 1'b0;
    logic irq_i = 1'b0;
    logic [47:0] insn_i = '0;
    logic [31:0] pc_i = '0;
    logic [31:0] op_a_i = '0;
    logic [31:0] op_b_i = '0;
    logic busy_o, done_o, mem_req_o, mem_ack_i, sr_we_o, irq_take_o, ltake;
    logic [4:0] sr_num_o;
    logic [31:0] mem_addr_o, mem_rdata_i, irq_ret_pc_o, sr_data_o, psw_o, laddr, lret;
    logic [36:0] lsr;
    lmmx_wr_t wr_a_o, wr_b_o, la, lb;
    logic [3:0] dly = 4'h1;
    int errors = 0;
    int compares = 0;
    localparam logic [47:0] LOAD = {32'h0000FFF9, 5'h0C, LMMX_OP_LOAD, 5'h02};
    always #12.5 clk_i = ~clk_i;
    lmmx_exec uut (.clk_i, .rstn_i, .issue_i, .insn_i, .pc_i, .op_a_i, .op_b_i, .op_c_i(32'h0),
        .misalign_en_i, .irq_i, .busy_o, .done_o, .rs_a_o(), .rs_b_o(), .rs_c_o(), .wr_a_o,
        .wr_b_o, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i, .irq_take_o,
        .irq_ret_pc_o, .sr_we_o, .sr_num_o, .sr_data_o, .psw_o);
    lmmx_mem_model mem (.clk_i, .req_i(mem_req_o), .addr_i(mem_addr_o), .dly_i(dly),
        .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    always @(posedge clk_i) begin
        if (wr_a_o.en) la <= wr_a_o;
        if (wr_b_o.en) lb <= wr_b_o;
        if (mem_req_o) laddr <= mem_addr_o;
        if (irq_take_o) lret <= irq_ret_pc_o;
        if (irq_take_o) ltake <= 1'b1;
        if (sr_we_o) lsr <= {sr_num_o, sr_data_o};
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issues one instruction and waits until it finishes or is abandoned.
    task automatic run(input logic [47:0] ins, input logic [31:0] a, input logic [31:0] b);
        int n = 0;
        {la, lb, ltake, lsr} = '0;
        insn_i = ins;
        op_a_i = a;
        op_b_i = b;
        issue_i = 1'b1;
        @(posedge clk_i);
        #2;
        issue_i = 1'b0;
        while (done_o !== 1'b1 && irq_take_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #2;
            n++;
        end
        if (n == 20) errors++;
        @(posedge clk_i);
        #2;
    endtask
    task automatic t_load();
        run(LOAD, 32'h10000003, 32'h0);
        check(laddr, 32'h0FFFFFF8);
        check(la, {1'b1, 5'h0C, 32'hF0000007});
        misalign_en_i = 1'b1;
        dly = 4'h3;
        run(LOAD, 32'h10000003, 32'h0);
        check(laddr, 32'h0FFFFFFB);
        check(la.data, 32'hF0000004);
        misalign_en_i = 1'b0;
    endtask
    // Only the status word number is targeted, never a reserved one.
    task automatic t_irq();
        run({21'h0, LMMX_SUB_SYSTEM_REGISTER_WRITE, LMMX_PSW_NUM, LMMX_OP_EXT, 5'h03}, 32'h0, 32'h0);
        check(lsr, {LMMX_PSW_NUM, 32'h0});
        check(psw_o, 32'h0);
        irq_i = 1'b1;
        dly = 4'h5;
        pc_i = 32'h00000400;
        run(LOAD, 32'h10000003, 32'h0);
        check({ltake, la.en, lret}, {2'b10, 32'h00000400});
        run({21'h0, LMMX_SUB_SYSTEM_REGISTER_WRITE, LMMX_PSW_NUM, LMMX_OP_EXT, 5'h03}, 32'h20, 32'h0);
        check({ltake, lsr}, {1'b0, LMMX_PSW_NUM, 32'h20});
        run(LOAD, 32'h10000003, 32'h0);
        check({ltake, la.en}, 2'b01);
        irq_i = 1'b0;
    endtask
    // Destinations are never the zero register here.
    task automatic t_moves();
        run({32'h0, 5'h07, LMMX_OP_COPY, 5'h03}, 32'hA5A50001, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h07, 32'hA5A50001});
        run({32'h0, 5'h07, LMMX_OP_COPYI, 5'h1A}, 32'h0, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h07, 32'hFFFFFFFA});
        run({32'h12345678, 5'h00, LMMX_OP_ADDRESS_ADD_IMMEDIATE, 5'h09}, 32'h0, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h09, 32'h12345678});
        run({32'h00008000, 5'h08, LMMX_OP_ADDRESS_ADD_IMMEDIATE, 5'h04}, 32'h00010000, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h08, 32'h00008000});
        run({32'h00008001, 5'h08, LMMX_OP_HIGH_HALFWORD_ADD, 5'h04}, 32'h00001234, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h08, 32'h80011234});
        check(psw_o, 32'h20);
    endtask
    // The first source differs from the high destination.
    task automatic t_mul();
        run({16'h0, 5'h06, LMMX_SUB_MUL, 5'h04, LMMX_OP_EXT, 5'h01}, 32'hFFFFFFFD, 32'h40000001);
        check(la, {1'b1, 5'h06, 32'hFFFFFFFF});
        check(lb, {1'b1, 5'h04, 32'h3FFFFFFD});
        run({16'h0, 5'h04, LMMX_SUB_MUL, 5'h04, LMMX_OP_EXT, 5'h01}, 32'hFFFFFFFD, 32'h40000001);
        check(la, {1'b1, 5'h04, 32'hFFFFFFFF});
        run({16'h0, 5'h06, 5'h09, 4'hF, 2'b00, 5'h04, LMMX_OP_EXT, 5'h1F}, 32'h0, 32'h00000005);
        check(la, {1'b1, 5'h06, 32'hFFFFFFFF});
        check(lb, {1'b1, 5'h04, 32'hFFFFFFFB});
        run({32'h0, 5'h05, LMMX_OP_HALFWORD_PRODUCT, 5'h02}, 32'hFFFF0003, 32'h12340005);
        check(la.en ? la : lb, {1'b1, 5'h05, 32'h0000000F});
        run({32'h0, 5'h05, LMMX_OP_MULHI5, 5'h1E}, 32'h0, 32'hABCD0010);
        check(la.en ? la : lb, {1'b1, 5'h05, 32'hFFFFFFE0});
        run({32'h0100, 5'h05, LMMX_OP_HALFWORD_IMMEDIATE_PRODUCT, 5'h02}, 32'hFFFF0003, 32'h0);
        check(la.en ? la : lb, {1'b1, 5'h05, 32'h00000300});
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        #2;
        rstn_i = 1'b1;
        t_load();
        t_irq();
        t_moves();
        t_mul();
        end_sim();
    end
    initial begin
        #50000;
        errors++;
        end_sim();
    end
endmodule
bind lmmx_exec lmmx_exec_sva chk (.clk_i, .rstn_i, .issue_i, .misalign_en_i, .irq_i, .insn_i,
    .op_a_i, .op_b_i, .mem_rdata_i, .mem_addr_o, .sr_data_o, .psw_o, .busy_o, .done_o,
    .mem_req_o, .mem_ack_i, .irq_take_o, .sr_we_o, .sr_num_o, .wr_a_o, .wr_b_o);

/* File: verif/lmmx_mem_model.sv */
// Data memory model that answers a word read after a set number of cycles.
`timescale 1ns/1ps
module lmmx_mem_model (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    input wire logic [3:0] dly_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [3:0] cnt = 4'h0;
    initial ack_o = 1'b0;
    initial rdata_o = 32'h0;
    // Outside an answer the data lines toggle so stale data never looks valid.
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        rdata_o <= ~rdata_o;
        cnt <= 4'h0;
        if (req_i && !ack_o) begin
            cnt <= cnt + 4'h1;
            if (cnt >= dly_i) begin
                ack_o <= 1'b1;
                rdata_o <= ~addr_i;
            end
        end
    end
endmodule
